//--- hwsp_shaping_regs.sv
// register bank and level references for library waveform shaping
`timescale 1ns/100ps
// Overview of operation
// - negative samples other than braking form the negative sustain portion
// - negative sustain offset field is signed two's complement
// - negative sustain adjustment equals offset times sample step period
// - the most negative waveform level is the braking portion
// - brake offset applies in open loop only, ignored in closed loop
// - brake offset is signed, adjustment equals offset times step period
// - full scale reference sets closed loop full scale, resets to 0x3F
// - full scale reference is ignored in open loop
// - calibration reads full scale reference; host writes rated level first
// - closed loop auto overdrive and braking may exceed rated level
// - auto overdrive is limited by overdrive limit level, resets to 0x89
// - overdrive limit level is the open loop full scale reference
module hwsp_shaping_regs (
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_n_in,
    input  wire logic [7:0]                   reg_addr_in,
    input  wire logic [7:0]                   reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic [7:0]                        reg_rdata_out,
    output logic                              reg_rvalid_out,
    input  wire logic                         closed_loop_in,
    input  wire logic [7:0]                   step_period_in,
    input  wire logic                         wave_start_in,
    input  wire logic                         scan_valid_in,
    input  wire logic signed [7:0]            scan_level_in,
    input  wire logic                         seg_valid_in,
    input  wire logic signed [7:0]            seg_level_in,
    input  wire logic [7:0]                   seg_steps_in,
    output logic                              seg_valid_out,
    output logic [1:0]                        seg_kind_out,
    output logic [hwsp_pkg::ADJ_W-1:0]        seg_steps_out,
    output logic [hwsp_pkg::MS_W-1:0]         seg_ms_out,
    input  wire logic                         drive_valid_in,
    input  wire logic [7:0]                   drive_req_in,
    input  wire logic                         drive_auto_in,
    output logic [7:0]                        drive_level_out,
    output logic [7:0]                        full_scale_out,
    output logic [7:0]                        cal_ref_level_out
);
    logic [7:0]                  neg_sustain_time_adjust_ff;
    logic [7:0]                  brake_time_adjust_ff;
    logic [7:0]                  full_scale_reference_level_ff;
    logic [7:0]                  overdrive_limit_level_ff;
    logic signed [7:0]           wave_max_ff;
    logic signed [7:0]           wave_min_ff;
    hwsp_pkg::hwsp_seg_kind_t    nxt_kind;
    logic [hwsp_pkg::ADJ_W-1:0]  nxt_steps;
    logic [hwsp_pkg::MS_W-1:0]   nxt_ms;
    logic [7:0]                  nxt_rdata;
    logic [7:0]                  nxt_full_scale;
    logic [7:0]                  nxt_limit;
    logic [7:0]                  nxt_drive_level;
    logic [3:0]                  wr_sel;
    logic [3:0]                  rd_sel;

    // one-hot select of the mapped registers, shared by writes and reads
    function automatic logic [3:0] reg_select(input logic [7:0] addr);
        logic [3:0] sel;
        unique case (addr)
            hwsp_pkg::OFS_NEG_SUSTAIN: sel = 4'h1;
            hwsp_pkg::OFS_BRAKE:       sel = 4'h2;
            hwsp_pkg::OFS_FULL_SCALE:  sel = 4'h4;
            hwsp_pkg::OFS_OD_LIMIT:    sel = 4'h8;
            default:                   sel = 4'h0;
        endcase
        return sel;
    endfunction : reg_select

    // unmapped accesses fall through silently, nothing is flagged to the host
    always_comb begin
        wr_sel = reg_wr_in ? reg_select(reg_addr_in) : 4'h0;
        rd_sel = reg_select(reg_addr_in);
    end

    // signed step offset for the negative sustain portion
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            neg_sustain_time_adjust_ff <= hwsp_pkg::RST_NEG_SUSTAIN;
        end else if (wr_sel[0]) begin
            neg_sustain_time_adjust_ff <= reg_wdata_in;
        end
    end

    // signed step offset for the braking portion
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brake_time_adjust_ff <= hwsp_pkg::RST_BRAKE;
        end else if (wr_sel[1]) begin
            brake_time_adjust_ff <= reg_wdata_in;
        end
    end

    // rated level; calibration depends on it, so rewrite means recalibrate
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            full_scale_reference_level_ff <= hwsp_pkg::RST_FULL_SCALE;
        end else if (wr_sel[2]) begin
            full_scale_reference_level_ff <= reg_wdata_in;
        end
    end

    // overdrive limit, doubles as open loop full scale
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overdrive_limit_level_ff <= hwsp_pkg::RST_OD_LIMIT;
        end else if (wr_sel[3]) begin
            overdrive_limit_level_ff <= reg_wdata_in;
        end
    end

    always_comb begin
        unique case (rd_sel)
            4'h1:    nxt_rdata = neg_sustain_time_adjust_ff;
            4'h2:    nxt_rdata = brake_time_adjust_ff;
            4'h4:    nxt_rdata = full_scale_reference_level_ff;
            4'h8:    nxt_rdata = overdrive_limit_level_ff;
            default: nxt_rdata = hwsp_pkg::RDATA_UNMAPPED;
        endcase
    end

    // register reads, answered one cycle after the request
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= nxt_rdata;
            end
        end
    end

    // extremes of the waveform; a start sample seeds both trackers
    // limitation: the whole waveform must be scanned before its first portion
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wave_max_ff <= hwsp_pkg::LVL_MAX_INIT;
            wave_min_ff <= hwsp_pkg::LVL_MIN_INIT;
        end else if (wave_start_in) begin
            wave_max_ff <= scan_valid_in ? scan_level_in : hwsp_pkg::LVL_MAX_INIT;
            wave_min_ff <= scan_valid_in ? scan_level_in : hwsp_pkg::LVL_MIN_INIT;
        end else if (scan_valid_in) begin
            if (scan_level_in > wave_max_ff) begin
                wave_max_ff <= scan_level_in;
            end
            if (scan_level_in < wave_min_ff) begin
                wave_min_ff <= scan_level_in;
            end
        end
    end

    // classification sees the extremes as they stood before this edge
    hwsp_seg_adjust u_seg_adjust (
        .level_in           (seg_level_in),
        .steps_in           (seg_steps_in),
        .wave_max_in        (wave_max_ff),
        .wave_min_in        (wave_min_ff),
        .closed_loop_in     (closed_loop_in),
        .neg_sustain_adj_in (neg_sustain_time_adjust_ff),
        .brake_adj_in       (brake_time_adjust_ff),
        .step_period_in     (step_period_in),
        .kind_out           (nxt_kind),
        .adj_steps_out      (nxt_steps),
        .adj_ms_out         (nxt_ms)
    );

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seg_valid_out <= 1'b0;
            seg_kind_out  <= 2'h0;
            seg_steps_out <= '0;
            seg_ms_out    <= '0;
        end else begin
            seg_valid_out <= seg_valid_in;
            if (seg_valid_in) begin
                seg_kind_out  <= 2'(nxt_kind);
                seg_steps_out <= nxt_steps;
                seg_ms_out    <= nxt_ms;
            end
        end
    end

    // open loop takes its full scale from the overdrive limit
    always_comb begin
        nxt_full_scale = closed_loop_in ? full_scale_reference_level_ff
                                        : overdrive_limit_level_ff;
        // auto overdrive and braking may pass rated, but never the limit
        if (closed_loop_in && drive_auto_in) begin
            nxt_limit = overdrive_limit_level_ff;
        end else begin
            nxt_limit = nxt_full_scale;
        end
        // unsigned magnitude compare; drive polarity is handled downstream
        if (drive_req_in > nxt_limit) begin
            nxt_drive_level = nxt_limit;
        end else begin
            nxt_drive_level = drive_req_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drive_level_out   <= 8'h00;
            full_scale_out    <= hwsp_pkg::RST_OD_LIMIT;
            cal_ref_level_out <= hwsp_pkg::RST_FULL_SCALE;
        end else begin
            full_scale_out    <= nxt_full_scale;
            cal_ref_level_out <= full_scale_reference_level_ff;
            if (drive_valid_in) begin
                drive_level_out <= nxt_drive_level;
            end
        end
    end
endmodule : hwsp_shaping_regs

//--- hwsp_pkg.sv
// constants and types shared by the waveform shaping parameter block
package hwsp_pkg;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned STEPS_W    = 8;
    localparam int unsigned ADJ_W      = 9;
    localparam int unsigned MS_W       = 17;
    localparam int unsigned SUM_W      = 10;

    localparam logic [7:0] OFS_NEG_SUSTAIN = 8'h0F;
    localparam logic [7:0] OFS_BRAKE       = 8'h10;
    localparam logic [7:0] OFS_FULL_SCALE  = 8'h16;
    localparam logic [7:0] OFS_OD_LIMIT    = 8'h17;

    localparam logic [7:0] RST_NEG_SUSTAIN = 8'h00;
    localparam logic [7:0] RST_BRAKE       = 8'h00;
    localparam logic [7:0] RST_FULL_SCALE  = 8'h3F;
    localparam logic [7:0] RST_OD_LIMIT    = 8'h89;

    localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;
    localparam logic signed [7:0] LVL_MAX_INIT = 8'sh80;
    localparam logic signed [7:0] LVL_MIN_INIT = 8'sh7F;

    typedef enum logic [1:0] {
        HWSP_SEG_OVERDRIVE,
        HWSP_SEG_POS_SUSTAIN,
        HWSP_SEG_NEG_SUSTAIN,
        HWSP_SEG_BRAKE
    } hwsp_seg_kind_t;
endpackage : hwsp_pkg

//--- hwsp_seg_adjust.sv
// classifies one waveform portion and works out its adjusted length
`timescale 1ns/100ps
module hwsp_seg_adjust (
    input  wire logic signed [7:0]                 level_in,
    input  wire logic [hwsp_pkg::STEPS_W-1:0]      steps_in,
    input  wire logic signed [7:0]                 wave_max_in,
    input  wire logic signed [7:0]                 wave_min_in,
    input  wire logic                              closed_loop_in,
    input  wire logic [7:0]                        neg_sustain_adj_in,
    input  wire logic [7:0]                        brake_adj_in,
    input  wire logic [7:0]                        step_period_in,
    output hwsp_pkg::hwsp_seg_kind_t               kind_out,
    output logic [hwsp_pkg::ADJ_W-1:0]             adj_steps_out,
    output logic [hwsp_pkg::MS_W-1:0]              adj_ms_out
);
    logic signed [7:0]                 offset;
    logic signed [hwsp_pkg::SUM_W-1:0] sum;

    always_comb begin
        offset = 8'sh00;
        if (level_in > 8'sh00 && level_in == wave_max_in) begin
            kind_out = hwsp_pkg::HWSP_SEG_OVERDRIVE;
        end else if (level_in >= 8'sh00) begin
            kind_out = hwsp_pkg::HWSP_SEG_POS_SUSTAIN;
        end else if (level_in == wave_min_in) begin
            kind_out = hwsp_pkg::HWSP_SEG_BRAKE;
            // closed loop brakes on its own, the offset must not stretch it
            if (!closed_loop_in) begin
                offset = $signed(brake_adj_in);
            end
        end else begin
            kind_out = hwsp_pkg::HWSP_SEG_NEG_SUSTAIN;
            offset   = $signed(neg_sustain_adj_in);
        end
        sum = $signed({2'b00, steps_in}) + hwsp_pkg::SUM_W'(offset);
        // clip at zero so a long negative offset never wraps
        if (sum < 0) begin
            adj_steps_out = '0;
        end else begin
            adj_steps_out = sum[hwsp_pkg::ADJ_W-1:0];
        end
        adj_ms_out = hwsp_pkg::MS_W'(adj_steps_out * step_period_in);
    end
endmodule : hwsp_seg_adjust

//--- hwsp_shaping_regs_chk.sv
// port checker for the shaping register block
`timescale 1ns/100ps
module hwsp_shaping_regs_chk (
    input wire logic              clk_sys_in,
    input wire logic              rst_n_in,
    input wire logic              reg_rd_in,
    input wire logic              reg_rvalid_out,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              closed_loop_in,
    input wire logic [7:0]        step_period_in,
    input wire logic              seg_valid_in,
    input wire logic signed [7:0] seg_level_in,
    input wire logic [7:0]        seg_steps_in,
    input wire logic              seg_valid_out,
    input wire logic [1:0]        seg_kind_out,
    input wire logic [8:0]        seg_steps_out,
    input wire logic [16:0]       seg_ms_out,
    input wire logic [7:0]        full_scale_out,
    input wire logic [7:0]        cal_ref_level_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_seg_out;
        ##1 seg_valid_out;
    endsequence
    a_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_rd_quiet: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("read answer without request");
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    a_seg_answer: assert property (seg_valid_in |-> s_seg_out)
        else $error("portion not answered");
    a_seg_sign: assert property (seg_valid_in
        |=> seg_kind_out[1] == $past(seg_level_in[7])) else $error("portion kind wrong sign");
    a_pos_steps: assert property (seg_valid_in && !seg_level_in[7]
        |=> seg_steps_out == {1'b0, $past(seg_steps_in)}) else $error("positive portion changed");
    a_seg_ms: assert property (seg_valid_out
        |-> seg_ms_out == 17'(seg_steps_out) * 17'($past(step_period_in))) else $error("ms wrong");
    // both outputs lag the register by one edge, so they agree
    a_fs_closed: assert property (closed_loop_in
        |=> full_scale_out == cal_ref_level_out) else $error("closed loop full scale wrong");
endmodule : hwsp_shaping_regs_chk
bind hwsp_shaping_regs hwsp_shaping_regs_chk u_chk (.clk_sys_in, .rst_n_in, .reg_rd_in,
    .reg_rvalid_out, .reg_rdata_out, .closed_loop_in, .step_period_in, .seg_valid_in,
    .seg_level_in, .seg_steps_in, .seg_valid_out, .seg_kind_out, .seg_steps_out, .seg_ms_out,
    .full_scale_out, .cal_ref_level_out);

//--- hwsp_host_model.sv
// host model issuing register accesses to the shaping block
`timescale 1ns/100ps
module hwsp_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output logic [7:0]      addr_out = 8'h00,
    output logic [7:0]      wdata_out = 8'h00,
    output logic            wr_out = 1'b0,
    output logic            rd_out = 1'b0
);
    // rated level written before calibration, recalibrate after a change
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_sys_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_sys_in);
        rd_out = 1'b0;
        v = rvalid_in;
        d = rdata_in;
    endtask : read_reg
endmodule : hwsp_host_model

//--- tb_top.sv
// self-checking bench for the shaping register block
`timescale 1ns/100ps
module tb_top;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, closed_loop_in = 1'b0, wave_start_in = 1'b0;
    logic scan_valid_in = 1'b0, seg_valid_in = 1'b0, drive_valid_in = 1'b0;
    logic drive_auto_in = 1'b0, reg_wr_in, reg_rd_in, reg_rvalid_out, seg_valid_out, v;
    logic [7:0] step_period_in = 8'h05, scan_level_in = 8'h00, seg_level_in = 8'h00;
    logic [7:0] seg_steps_in = 8'h00, drive_req_in = 8'h00, reg_addr_in, reg_wdata_in, d;
    logic [7:0] reg_rdata_out, drive_level_out, full_scale_out, cal_ref_level_out;
    logic [1:0] seg_kind_out;
    logic [8:0] seg_steps_out;
    logic [16:0] seg_ms_out;
    logic [7:0] ofs [4] = '{8'h0F, 8'h10, 8'h16, 8'h17};
    logic [7:0] rstv [4] = '{8'h00, 8'h00, 8'h3F, 8'h89};
    logic [7:0] val [4] = '{8'h02, 8'hFE, 8'h50, 8'h60};
    int bad_count = 0, total_checks = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    hwsp_host_model host (.clk_sys_in, .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
    hwsp_shaping_regs DUT (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .closed_loop_in, .step_period_in,
        .wave_start_in, .scan_valid_in, .scan_level_in, .seg_valid_in, .seg_level_in,
        .seg_steps_in, .seg_valid_out, .seg_kind_out, .seg_steps_out, .seg_ms_out,
        .drive_valid_in, .drive_req_in, .drive_auto_in, .drive_level_out, .full_scale_out,
        .cal_ref_level_out);
    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, d, v);
        chk("rvalid", 17'h1, 17'(v));
        chk("rdata", 17'(e), 17'(d));
    endtask : rdc
    task automatic seg(input logic [7:0] l, s, input logic [1:0] k, input logic [8:0] n,
                       input logic [16:0] m);
        @(negedge clk_sys_in);
        seg_valid_in = 1'b1;
        seg_level_in = l;
        seg_steps_in = s;
        @(negedge clk_sys_in);
        seg_valid_in = 1'b0;
        chk("seg_valid", 17'h1, 17'(seg_valid_out));
        chk("seg_kind", 17'(k), 17'(seg_kind_out));
        chk("seg_steps", 17'(n), 17'(seg_steps_out));
        chk("seg_ms", m, seg_ms_out);
    endtask : seg
    task automatic drv(input logic [7:0] r, input logic a, input logic [7:0] e);
        @(negedge clk_sys_in);
        drive_valid_in = 1'b1;
        drive_req_in = r;
        drive_auto_in = a;
        @(negedge clk_sys_in);
        drive_valid_in = 1'b0;
        chk("drive_level", 17'(e), 17'(drive_level_out));
    endtask : drv
    task automatic results;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk("full_scale", 17'h89, 17'(full_scale_out));
        chk("cal_ref", 17'h3F, 17'(cal_ref_level_out));
        foreach (ofs[i]) rdc(ofs[i], rstv[i]);
        host.write_reg(8'h11, 8'h5A);
        rdc(8'h11, 8'h00);
        foreach (ofs[i]) host.write_reg(ofs[i], val[i]);
        foreach (ofs[i]) rdc(ofs[i], val[i]);
        @(negedge clk_sys_in);
        wave_start_in = 1'b1;
        scan_valid_in = 1'b1;
        scan_level_in = 8'h40;
        @(negedge clk_sys_in);
        wave_start_in = 1'b0;
        scan_level_in = 8'hA0;
        @(negedge clk_sys_in);
        scan_valid_in = 1'b0;
        seg(8'hA0, 8'h03, 2'h3, 9'h1, 17'h5);
        seg(8'hC0, 8'h03, 2'h2, 9'h5, 17'h19);
        seg(8'h40, 8'h03, 2'h0, 9'h3, 17'hF);
        seg(8'h10, 8'h03, 2'h1, 9'h3, 17'hF);
        host.write_reg(8'h0F, 8'h7F);
        step_period_in = 8'hFF;
        seg(8'hC0, 8'hFF, 2'h2, 9'h17E, 17'h17C82);
        step_period_in = 8'h05;
        host.write_reg(8'h0F, 8'h81);
        seg(8'hC0, 8'h03, 2'h2, 9'h0, 17'h0);
        closed_loop_in = 1'b1;
        seg(8'hA0, 8'h03, 2'h3, 9'h3, 17'hF);
        chk("full_scale", 17'h50, 17'(full_scale_out));
        chk("cal_ref", 17'h50, 17'(cal_ref_level_out));
        drv(8'hFF, 1'b1, 8'h60);
        drv(8'hFF, 1'b0, 8'h50);
        closed_loop_in = 1'b0;
        drv(8'hFF, 1'b0, 8'h60);
        chk("full_scale", 17'h60, 17'(full_scale_out));
        drv(8'h10, 1'b1, 8'h10);
        results();
    end
    // run needs about 1.6 us; this leaves a wide margin
    initial begin
        #50000;
        bad_count++;
        results();
    end
endmodule : tb_top
